// ==== logic/srs_defines.svh ====
// Constants of the system reset sequencer
`ifndef SRS_DEFINES_SVH
`define SRS_DEFINES_SVH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SRS_CLK_HZ          20000000
`define SRS_REL_DELAY_US    300
`define SRS_REL_DELAY_CYC   ((`SRS_REL_DELAY_US * (`SRS_CLK_HZ / 1000000)))
`define SRS_WDT_DIV         12
// ----------------------------------------------------------------
// Register map, word offsets as byte addresses
// ----------------------------------------------------------------
`define SRS_ADDR_CAUSE      4'h0
`define SRS_ADDR_MON        4'h4
`define SRS_ADDR_CTRL       4'h8
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SRS_CAUSE_POR_BIT   1
`define SRS_CAUSE_MON_BIT   2
`define SRS_CAUSE_SW_BIT    4
`define SRS_MON_EN_BIT      7
`define SRS_MON_STAT_BIT    6
`define SRS_MON_SEL_BIT     0
`define SRS_CTRL_OSC_BIT    0
`define SRS_CTRL_WDT_BIT    1
`define SRS_PORT_RESET      8'hFF
`define SRS_PC_RESET        16'h0000
`endif

// ==== logic/srs_pkg.sv ====
// Types of the system reset sequencer
package srs_pkg;
	typedef enum logic [1:0] {
		SRS_POWER = 2'b00,
		SRS_WAIT  = 2'b01,
		SRS_RUN   = 2'b11,
		SRS_MONR  = 2'b10
	} srs_state_t;

	typedef struct packed {
		logic por_m;
		logic por_s;
		logic good_m;
		logic good_s;
	} srs_sync_t;

	typedef struct packed {
		srs_state_t  st;
		srs_sync_t   sy;
		logic [13:0] cnt;
		logic [3:0]  wdiv;
		logic        por_flag;
		logic        mon_flag;
		logic        sw_flag;
		logic        mon_en;
		logic        mon_sel;
		logic        osc_ext;
		logic        wdt_en;
		logic        sw_req;
		logic        hold;
		logic        pin_oe;
		logic        wdt_tick;
		logic        ack;
		logic [31:0] dat;
	} srs_state_all_t;
endpackage

// ==== logic/srs_sequencer.sv ====
// System reset sequencer: holds core and peripherals in reset, drives reset pin
//
// Contract
// RQ1 - Processor is halted while in reset.
// RQ2 - Registers take their reset values on entering reset.
// RQ3 - Port pins are forced to a known state on reset.
// RQ4 - Interrupts and timers are disabled on reset.
// RQ5 - Data memory is kept; stack pointer still reset.
// RQ6 - Port latches 0xFF open-drain; weak pull-ups stay enabled.
// RQ7 - Power-on and supply-monitor resets drive reset pin low throughout.
// RQ8 - Program counter cleared on exit; execution starts at 0x0000.
// RQ9 - Internal oscillator selected as clock on exit.
// RQ10 - Watchdog enabled on exit, clocked by system clock over 12.
// RQ11 - At power-up hold reset and pin low until supply good.
// RQ12 - Extra release delay after supply good, under 0.3 ms; here 6000 clocks, 0.3 ms at 20 MHz, after two sync clocks.
// RQ13 - Leaving power-on reset sets power-on flag, cause bit 1.
// RQ14 - Other cause flags undefined while power-on flag set.
// RQ15 - Any non power-on reset clears the power-on flag.
// RQ16 - Supply monitor left enabled after power-on reset.
// RQ17 - Selected monitor with low supply holds reset; release on recovery.
// RQ18 - No release delay after a supply-monitor reset.
// RQ19 - Only power-on reset changes the monitor enable setting.
// RQ20 - Async inputs synchronised for release; assertion acts at once.
// RQ21 - Release counter restarts on supply drop; release at expiry.
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
`include "srs_defines.svh"

module srs_sequencer
	import srs_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        por_i,
	input  wire logic        supply_good_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             core_hold_o,
	output logic             rst_pin_o,
	output logic             rst_pin_oe_o,
	output logic             osc_ext_o,
	output logic             wdt_en_o,
	output logic             wdt_tick_o
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	localparam logic [13:0] REL_CYC = 14'(`SRS_REL_DELAY_CYC);
	localparam logic [3:0]  WDT_TOP = 4'(`SRS_WDT_DIV - 1);

	srs_state_all_t s_r;
	srs_state_all_t s_nxt;

	logic por_now;
	logic mon_low;
	logic wb_req;
	logic wb_wr;
	logic [31:0] rd_val;

	// Assertion uses raw inputs so reset is never delayed by the synchroniser
	assign por_now = por_i;                                        // [RQ20]
	// Power-up path owns a low supply; the monitor only guards a running part
	assign mon_low = s_r.mon_en && s_r.mon_sel && !supply_good_i
		&& (s_r.st == SRS_RUN || s_r.st == SRS_MONR);               // [RQ17]
	assign wb_req  = wb_cyc_i && wb_stb_i && !s_r.ack;
	// Write lands on the edge at which the master sees ack
	assign wb_wr   = wb_cyc_i && wb_stb_i && wb_we_i && s_r.ack;

	// ----------------------------------------------------------------
	// Register read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (wb_adr_i)
			`SRS_ADDR_CAUSE: begin
				rd_val[`SRS_CAUSE_POR_BIT] = s_r.por_flag;
				// Undefined while power-on flag set; read as zero
				rd_val[`SRS_CAUSE_MON_BIT] = s_r.mon_flag && !s_r.por_flag; // [RQ14]
				rd_val[`SRS_CAUSE_SW_BIT]  = s_r.sw_flag && !s_r.por_flag;  // [RQ14]
			end
			`SRS_ADDR_MON: begin
				rd_val[`SRS_MON_EN_BIT]   = s_r.mon_en;
				rd_val[`SRS_MON_STAT_BIT] = s_r.sy.good_s;
				rd_val[`SRS_MON_SEL_BIT]  = s_r.mon_sel;
			end
			`SRS_ADDR_CTRL: begin
				rd_val[`SRS_CTRL_OSC_BIT] = s_r.osc_ext;
				rd_val[`SRS_CTRL_WDT_BIT] = s_r.wdt_en;
			end
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt          = s_r;
		s_nxt.sy.por_m  = por_i;
		s_nxt.sy.por_s  = s_r.sy.por_m;
		s_nxt.sy.good_m = supply_good_i;
		s_nxt.sy.good_s = s_r.sy.good_m;
		s_nxt.ack      = wb_req;
		s_nxt.wdt_tick = 1'b0;
		s_nxt.sw_req   = 1'b0;
		if (wb_req && !wb_we_i) begin
			s_nxt.dat = rd_val;
		end

		// Watchdog prescale: one pulse every twelve clocks
		if (s_r.wdt_en && !s_r.hold) begin
			if (s_r.wdiv == WDT_TOP) begin
				s_nxt.wdiv     = 4'h0;
				s_nxt.wdt_tick = 1'b1;                         // [RQ10]
			end else begin
				s_nxt.wdiv = s_r.wdiv + 4'h1;
			end
		end

		// Register writes only while running
		if (wb_wr && s_r.st == SRS_RUN) begin
			unique case (wb_adr_i)
				`SRS_ADDR_CAUSE: begin
					if (wb_sel_i[0] && wb_dat_i[`SRS_CAUSE_SW_BIT]) begin
						s_nxt.sw_req = 1'b1;
					end
				end
				`SRS_ADDR_MON: begin
					if (wb_sel_i[0]) begin
						s_nxt.mon_en  = wb_dat_i[`SRS_MON_EN_BIT];
						s_nxt.mon_sel = wb_dat_i[`SRS_MON_SEL_BIT];
					end
				end
				`SRS_ADDR_CTRL: begin
					if (wb_sel_i[0]) begin
						s_nxt.osc_ext = wb_dat_i[`SRS_CTRL_OSC_BIT];
						s_nxt.wdt_en  = wb_dat_i[`SRS_CTRL_WDT_BIT];
					end
				end
				default: ;
			endcase
		end

		// ----------------------------------------------------------------
		// Sequencer
		// ----------------------------------------------------------------
		if (por_now) begin
			s_nxt.st     = SRS_POWER;                              // [RQ20]
			s_nxt.hold   = 1'b1;                                   // [RQ1] [RQ11]
			s_nxt.pin_oe = 1'b1;                                   // [RQ7] [RQ11]
			s_nxt.cnt    = 14'h0000;
			s_nxt.mon_en = 1'b1;                                   // [RQ16] [RQ19]
			s_nxt.mon_sel = 1'b1;                                  // [RQ16]
			s_nxt.osc_ext = 1'b0;                                  // [RQ2] [RQ9]
			s_nxt.wdt_en = 1'b0;                                   // [RQ4]
			s_nxt.wdiv   = 4'h0;
		end else if (mon_low) begin
			s_nxt.st      = SRS_MONR;                              // [RQ17]
			s_nxt.hold    = 1'b1;                                  // [RQ1]
			s_nxt.pin_oe  = 1'b1;                                  // [RQ7]
			s_nxt.osc_ext = 1'b0;                                  // [RQ2] [RQ9]
			s_nxt.wdt_en  = 1'b0;                                  // [RQ4]
			s_nxt.wdiv    = 4'h0;
		end else if (s_r.sw_req) begin
			// Software reset: one cycle hold, pin not driven, monitor kept
			s_nxt.hold     = 1'b1;                                 // [RQ1] [RQ19]
			s_nxt.osc_ext  = 1'b0;                                 // [RQ2]
			s_nxt.wdt_en   = 1'b0;                                 // [RQ4]
			s_nxt.por_flag = 1'b0;                                 // [RQ15]
			s_nxt.mon_flag = 1'b0;
			s_nxt.sw_flag  = 1'b1;
			// Restart prescale so the first tick keeps the full divide
			s_nxt.wdiv     = 4'h0;                                 // [RQ10]
			s_nxt.st       = SRS_RUN;
		end else begin
			unique case (s_r.st)
				SRS_POWER: begin
					if (!s_r.sy.por_s && s_r.sy.good_s) begin
						s_nxt.st  = SRS_WAIT;
						s_nxt.cnt = 14'h0000;
					end
				end
				SRS_WAIT: begin
					if (!s_r.sy.good_s) begin
						s_nxt.cnt = 14'h0000;                      // [RQ21]
					end else if (s_r.cnt == REL_CYC - 14'h0001) begin
						s_nxt.st       = SRS_RUN;                  // [RQ12] [RQ21]
						s_nxt.hold     = 1'b0;                     // [RQ8]
						s_nxt.pin_oe   = 1'b0;
						s_nxt.por_flag = 1'b1;                     // [RQ13]
						s_nxt.wdt_en   = 1'b1;                     // [RQ10]
					end else begin
						s_nxt.cnt = s_r.cnt + 14'h0001;
					end
				end
				SRS_MONR: begin
					// Recovery releases at once, no delay
					if (s_r.sy.good_s) begin
						s_nxt.st       = SRS_RUN;                  // [RQ18]
						s_nxt.hold     = 1'b0;                     // [RQ8]
						s_nxt.pin_oe   = 1'b0;
						s_nxt.por_flag = 1'b0;                     // [RQ15]
						s_nxt.mon_flag = 1'b1;
						s_nxt.sw_flag  = 1'b0;
						s_nxt.wdt_en   = 1'b1;                     // [RQ10]
					end
				end
				SRS_RUN: begin
					if (s_r.hold) begin
						s_nxt.hold   = 1'b0;                       // [RQ8]
						s_nxt.wdt_en = 1'b1;                       // [RQ10]
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r         <= '0;
			s_r.st      <= SRS_POWER;
			s_r.hold    <= 1'b1;
			s_r.pin_oe  <= 1'b1;
			s_r.mon_en  <= 1'b1;
			s_r.mon_sel <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Core side applies PC 0x0000, port latches 0xFF open-drain with pull-ups,
	// cleared SFRs and kept data memory while core_hold_o is high
	assign core_hold_o  = s_r.hold;                                // [RQ1] [RQ3] [RQ5] [RQ6]
	assign rst_pin_o    = 1'b0;
	assign rst_pin_oe_o = s_r.pin_oe;                              // [RQ7]
	assign osc_ext_o    = s_r.osc_ext;
	assign wdt_en_o     = s_r.wdt_en;
	assign wdt_tick_o   = s_r.wdt_tick;
	assign wb_ack_o     = s_r.ack;
	assign wb_dat_o     = s_r.dat;
endmodule // srs_sequencer

// ==== bench/srs_board.sv ====
// Board side model: pulled-up reset pin and a core program counter
`timescale 1ns/100ps
module srs_board (
	input  wire logic        clk_i,
	input  wire logic        hold_i,
	input  wire logic        pin_i,
	input  wire logic        pin_oe_i,
	output logic             pin_level_o,
	output logic      [15:0] pc_o
);
	// Pull-up wins once the sequencer lets go of the pin
	assign pin_level_o = pin_oe_i ? pin_i : 1'b1;
	// Core sits at the reset vector while held
	always_ff @(posedge clk_i)
		pc_o <= hold_i ? 16'h0000 : pc_o + 16'h0001;
endmodule // srs_board

// ==== bench/srs_sequencer_assertions.sv ====
// Port checks of the system reset sequencer
`timescale 1ns/100ps
module srs_sequencer_checker (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        por_i,
	input wire logic        supply_good_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        core_hold_o,
	input wire logic        rst_pin_o,
	input wire logic        rst_pin_oe_o,
	input wire logic        osc_ext_o,
	input wire logic        wdt_en_o,
	input wire logic        wdt_tick_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	pin_needs_hold_a: assert property (rst_pin_oe_o |-> core_hold_o)
		else $error("reset pin driven outside reset");
	por_hold_a: assert property (por_i |=> core_hold_o && rst_pin_oe_o)
		else $error("power-on request not acted on");
	pin_low_a: assert property (rst_pin_oe_o |-> !rst_pin_o)
		else $error("reset pin driven high");
	exit_defaults_a: assert property ($fell(core_hold_o) |-> wdt_en_o && !osc_ext_o)
		else $error("exit defaults missing");
	sync_release_a: assert property ($fell(core_hold_o) |-> $past(supply_good_i, 2))
		else $error("release without settled supply");
	tick_gap_a: assert property (wdt_tick_o |=> !wdt_tick_o [*8])
		else $error("watchdog ticks too close");
	ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus answer late");
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus answer too long");
	unmapped_zero_a: assert property (wb_ack_o && $past(wb_adr_i) == 4'hC |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	cover property ($fell(core_hold_o));
	cover property ($rose(rst_pin_oe_o) && !por_i);
	cover property (wdt_tick_o);
endmodule // srs_sequencer_checker
bind srs_sequencer srs_sequencer_checker srs_sequencer_checker_i (.clk_i, .rst_i, .por_i,
	.supply_good_i, .wb_cyc_i, .wb_stb_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .core_hold_o,
	.rst_pin_o, .rst_pin_oe_o, .osc_ext_o, .wdt_en_o, .wdt_tick_o);

// ==== bench/tb.sv ====
// Self-checking bench of the system reset sequencer
`timescale 1ns/100ps
module tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        por_i = 1'b1;
	logic        supply_good_i = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [3:0]  wb_adr_i = 4'h0;
	logic [3:0]  wb_sel_i = 4'h1;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o, core_hold_o, rst_pin_o, rst_pin_oe_o, osc_ext_o, wdt_en_o, wdt_tick_o;
	logic        pin_level;
	logic [15:0] pc;
	logic [31:0] exp_q[$];
	int          fail_count = 0;
	int          checks = 0;
	int          n;
	srs_sequencer srs_sequencer_i (.clk_i, .rst_i, .por_i, .supply_good_i, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .core_hold_o,
		.rst_pin_o, .rst_pin_oe_o, .osc_ext_o, .wdt_en_o, .wdt_tick_o);
	srs_board srs_board_i (.clk_i, .hold_i(core_hold_o), .pin_i(rst_pin_o),
		.pin_oe_i(rst_pin_oe_o), .pin_level_o(pin_level), .pc_o(pc));
	initial forever #25 clk_i = ~clk_i;
	// ------------------------------------------------
	// Shared tasks
	// ------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] expd);
		checks++;
		if (seen !== expd) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, expd);
		end
	endtask
	task automatic stop_test();
		if (fail_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] dat);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'h1;
		wb_dat_i <= dat;
		// Only the watchdog ends a wait for ack
		do
			@(posedge clk_i);
		while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] adr, input logic [31:0] expd);
		exp_q.push_back(expd);
		bus(1'b0, adr, 32'h0);
	endtask
	// Bounded waits; slow release is caught by the count checks, except the release after the software reset
	task automatic wait_hold(input logic lvl, output int cnt);
		cnt = 0;
		do begin
			@(posedge clk_i);
			cnt++;
		end while (core_hold_o !== lvl && cnt < 8000);
	endtask
	task automatic wait_tick(output int cnt);
		cnt = 0;
		do begin
			@(posedge clk_i);
			cnt++;
		end while (wdt_tick_o !== 1'b1 && cnt < 40);
	endtask
	always @(posedge clk_i)
		if (wb_ack_o === 1'b1 && !wb_we_i && exp_q.size() > 0)
			check(wb_dat_o, exp_q.pop_front());
	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	initial begin
		void'($urandom(32'h1029));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		repeat (50) @(posedge clk_i);
		check({core_hold_o, pin_level}, 2'b10);
		rd(4'hC, 32'h0);
		supply_good_i <= 1'b1;
		repeat (3000) @(posedge clk_i);
		supply_good_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		supply_good_i <= 1'b1;
		wait_hold(1'b0, n);
		check(n >= 6000 && n < 6010, 1'b1);
		check({osc_ext_o, wdt_en_o, pin_level, pc}, {3'b011, 16'h0000});
		rd(4'h0, 32'h2);
		rd(4'h4, 32'hC1);
		wait_tick(n);
		wait_tick(n);
		check(n, 12);
		supply_good_i <= 1'b0;
		repeat ($urandom_range(2, 9)) @(posedge clk_i);
		check({core_hold_o, pin_level}, 2'b10);
		supply_good_i <= 1'b1;
		wait_hold(1'b0, n);
		check(n < 10, 1'b1);
		rd(4'h0, 32'h4);
		rd(4'h4, 32'hC1);
		bus(1'b1, 4'h8, ($urandom() & 32'hFFFFFF00) | 32'h1);
		@(posedge clk_i);
		check(osc_ext_o, 1'b1);
		bus(1'b1, 4'h4, 32'h0);
		bus(1'b1, 4'h0, 32'h10);
		wait_hold(1'b1, n);
		check(n < 4, 1'b1);
		wait_hold(1'b0, n);
		check(osc_ext_o, 1'b0);
		rd(4'h0, 32'h10);
		rd(4'h4, 32'h40);
		supply_good_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		check(core_hold_o, 1'b0);
		supply_good_i <= 1'b1;
		por_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		check({core_hold_o, pin_level}, 2'b10);
		por_i <= 1'b0;
		wait_hold(1'b0, n);
		check(n >= 6000 && n < 6010, 1'b1);
		rd(4'h0, 32'h2);
		rd(4'h4, 32'hC1);
		stop_test();
	end
	initial begin
		#(50 * 25000);
		fail_count++;
		stop_test();
	end
endmodule // tb
